/* File: logic/oam_slice.sv */
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module oam_slice
  import oam_pkg::*;
(
  input  wire logic                  CLK,
  input  wire logic                  SYS_RST,
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [OAM_ADDR_W-1:0] PADDR,
  input  wire logic [31:0]           PWDATA,
  output var  logic [31:0]           PRDATA,
  output var  logic                  PREADY,
  output var  logic                  PSLVERR,
  output var  logic [7:0]            ACC,
  output var  logic                  ZERO
);

  // state and decode
  oam_state_t       st;
  oam_state_t       next_st;
  oam_dec_t         dec;
  logic [7:0]       opnd;
  logic [7:0]       res;
  logic [7:0]       res_lit;
  logic [7:0]       res_or;
  logic [7:0]       res_copy;
  logic             res_zero;
  logic [4:0]       fidx;

  // address decode and bus phases
  logic             hit_instr;
  logic             hit_acc;
  logic             hit_status;
  logic             hit_file;
  logic             hit_none;
  logic             setup;
  logic             access;

  // write strobes
  logic             wr_ok;
  logic             wr_instr;
  logic             wr_acc;
  logic             wr_status;
  logic             wr_file;

  // execution and register file
  logic             exec_acc;
  logic             exec_reg;
  logic             exec_zero;
  logic             exec_bad;
  logic [31:0]      rd_word;
  logic [31:0]      reg_we;
  logic [31:0][7:0] reg_wd;

  // instruction decode
  always_comb begin
    dec.op     = OAM_OP_NONE;
    dec.to_reg = PWDATA[OAM_D_BIT];
    dec.sel    = PWDATA[4:0];
    dec.lit    = PWDATA[7:0];
    if (PWDATA[11:8] == OAM_PAT_LIT) begin
      dec.op = OAM_OP_LIT;
    end else if (PWDATA[11:6] == OAM_PAT_OR) begin
      dec.op = OAM_OP_OR;
    end else if (PWDATA[11:6] == OAM_PAT_COPY) begin
      dec.op = OAM_OP_COPY;
    end
  end

  // register map decode
  assign fidx = PADDR[6:2];

  always_comb begin
    hit_instr  = 1'b0;
    hit_acc    = 1'b0;
    hit_status = 1'b0;
    hit_file   = 1'b0;
    hit_none   = 1'b1;
    if (PADDR == OAM_OFS_INSTR) begin
      hit_instr = 1'b1;
    end
    if (PADDR == OAM_OFS_ACC) begin
      hit_acc = 1'b1;
    end
    if (PADDR == OAM_OFS_STATUS) begin
      hit_status = 1'b1;
    end
    if ((PADDR & OAM_FILE_MASK) == OAM_OFS_FILE) begin
      if (PADDR[1:0] == 2'b00) begin
        hit_file = 1'b1;
      end
    end
    if (hit_instr || hit_acc || hit_status || hit_file) begin
      hit_none = 1'b0;
    end
  end

  // answer after setup, act on the completing edge
  assign setup     = PSEL && !PENABLE;
  assign access    = PSEL && PENABLE && st.pready;
  assign wr_ok     = access && PWRITE && !st.slverr;
  assign wr_instr  = wr_ok && hit_instr;
  assign wr_acc    = wr_ok && hit_acc;
  assign wr_status = wr_ok && hit_status;
  assign wr_file   = wr_ok && hit_file;

  // read data for the answer cycle
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_acc) begin
      rd_word[7:0] = st.acc;
    end else if (hit_status) begin
      rd_word[OAM_ST_ZERO] = st.zero;
      rd_word[OAM_ST_BAD]  = st.bad;
    end else if (hit_file) begin
      rd_word[7:0] = st.regs[fidx];
    end
  end

  // operand fetch and the three results
  assign opnd     = st.regs[dec.sel];
  assign res_lit  = st.acc | dec.lit;
  assign res_or   = st.acc | opnd;
  assign res_copy = opnd;

  // result routing per instruction
  always_comb begin
    res       = 8'h00;
    exec_acc  = 1'b0;
    exec_reg  = 1'b0;
    exec_zero = 1'b0;
    exec_bad  = 1'b0;
    case (dec.op)
      OAM_OP_LIT: begin
        res       = res_lit;
        exec_acc  = 1'b1;
        exec_zero = 1'b1;
      end
      OAM_OP_OR: begin
        res       = res_or;
        exec_acc  = !dec.to_reg;
        exec_reg  = dec.to_reg;
        exec_zero = 1'b1;
      end
      OAM_OP_COPY: begin
        res       = res_copy;
        exec_acc  = !dec.to_reg;
        exec_reg  = dec.to_reg;
        exec_zero = 1'b1;
      end
      default: begin
        // unknown words only raise the bad flag
        exec_bad = 1'b1;
      end
    endcase
  end

  assign res_zero = (res == 8'h00);

  // per-register write enable and write data
  for (genvar g = 0; g < OAM_NREGS; g++) begin : g_reg_wr
    assign reg_we[g] = (wr_instr && exec_reg && dec.sel == 5'(g)) ||
                       (wr_file && fidx == 5'(g));
    assign reg_wd[g] = wr_instr ? res : PWDATA[7:0];
  end

  // next state
  always_comb begin
    next_st        = st;
    next_st.pready = 1'b0;
    next_st.slverr = 1'b0;
    // answer in the first access cycle
    if (setup) begin
      next_st.pready = 1'b1;
      next_st.slverr = hit_none;
      next_st.prdata = rd_word;
    end
    // execution at the completing edge
    if (wr_instr) begin
      if (exec_acc) begin
        next_st.acc = res;
      end
      if (exec_zero) begin
        next_st.zero = res_zero;
      end
      if (exec_bad) begin
        next_st.bad = 1'b1;
      end
    end
    if (wr_acc) begin
      next_st.acc = PWDATA[7:0];
    end
    if (wr_status) begin
      next_st.zero = PWDATA[OAM_ST_ZERO];
      if (PWDATA[OAM_ST_BAD]) begin
        next_st.bad = 1'b0;
      end
    end
    // file writes from the bus or from execution
    for (int i = 0; i < int'(OAM_NREGS); i++) begin
      if (reg_we[i]) begin
        next_st.regs[i] = reg_wd[i];
      end
    end
    // synchronous reset wins
    if (SYS_RST) begin
      next_st = OAM_STATE_RST;
    end
  end

  // state register
  always_ff @(posedge CLK) begin
    st <= next_st;
  end

  // outputs straight from the state
  assign PRDATA  = st.prdata;
  assign PREADY  = st.pready;
  assign PSLVERR = st.slverr;
  assign ACC     = st.acc;
  assign ZERO    = st.zero;

endmodule
`default_nettype wire

/* File: logic/oam_pkg.sv */
// Behaviour
// - top nibble 1101: or literal into accumulator
// - 0001 00df ffff: or accumulator with register
// - target bit 0 accumulator, 1 register
// - 0010 00df ffff: copy register to target
// - copy sets zero flag even in place
package oam_pkg;

  localparam int unsigned OAM_DATA_W  = 8;
  localparam int unsigned OAM_WORD_W  = 12;
  localparam int unsigned OAM_NREGS   = 32;
  localparam int unsigned OAM_ADDR_W  = 12;

  localparam logic [11:0] OAM_OFS_INSTR  = 12'h000;
  localparam logic [11:0] OAM_OFS_ACC    = 12'h004;
  localparam logic [11:0] OAM_OFS_STATUS = 12'h008;
  localparam logic [11:0] OAM_OFS_FILE   = 12'h080;
  localparam logic [11:0] OAM_FILE_MASK  = 12'hF80;

  localparam int unsigned OAM_ST_ZERO = 0;
  localparam int unsigned OAM_ST_BAD  = 1;

  localparam logic [3:0] OAM_PAT_LIT  = 4'hD;
  localparam logic [5:0] OAM_PAT_OR   = 6'h04;
  localparam logic [5:0] OAM_PAT_COPY = 6'h08;

  localparam int unsigned OAM_D_BIT = 5;

  typedef enum logic [1:0] {
    OAM_OP_NONE = 2'b00,
    OAM_OP_LIT  = 2'b01,
    OAM_OP_OR   = 2'b10,
    OAM_OP_COPY = 2'b11
  } oam_op_t;

  typedef struct packed {
    oam_op_t    op;
    logic       to_reg;
    logic [4:0] sel;
    logic [7:0] lit;
  } oam_dec_t;

  typedef struct packed {
    logic [31:0][7:0] regs;
    logic [7:0]       acc;
    logic             zero;
    logic             bad;
    logic             pready;
    logic             slverr;
    logic [31:0]      prdata;
  } oam_state_t;

  localparam oam_state_t OAM_STATE_RST = '{default: '0};

endpackage

/* File: test/oam_props.sv */
`timescale 1ns/1ps
`default_nettype none
module oam_chk import oam_pkg::*; (
  input wire logic        CLK,
  input wire logic        SYS_RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic [7:0]  ACC,
  input wire logic        ZERO
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  wire logic       w = PSEL && PENABLE && PREADY && PWRITE && PADDR == 0;
  wire logic [5:0] p = PWDATA[11:6];
  a_or_literal:
    assert property (w && p[5:2] == OAM_PAT_LIT |=>
      ACC == ($past(ACC) | $past(PWDATA[7:0]))) else $error("or literal");
  a_or_grows:
    assert property (w && p == OAM_PAT_OR && !PWDATA[5] |=>
      (ACC & $past(ACC)) == $past(ACC)) else $error("or register");
  a_reg_target:
    assert property (w && (p == OAM_PAT_OR || p == OAM_PAT_COPY)
      && PWDATA[5] |=> $stable(ACC)) else $error("target register");
  a_copy_zero:
    assert property (w && p == OAM_PAT_COPY && !PWDATA[5] |=>
      ZERO == (ACC == 8'h00)) else $error("copy zero");
  a_lit_zero:
    assert property (w && p[5:2] == OAM_PAT_LIT |=>
      ZERO == (ACC == 8'h00)) else $error("literal zero");
  a_one_cycle:
    assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
      else $error("ready timing");
endmodule
bind oam_slice oam_chk u_chk(.CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE,
  .PADDR, .PWDATA, .PREADY, .ACC, .ZERO);
`default_nettype wire

/* File: test/oam_fetch.sv */
`timescale 1ns/1ps
`default_nettype none
module oam_fetch (
  input  wire logic        CLK,
  input  wire logic        PREADY,
  input  wire logic        PSLVERR,
  input  wire logic [31:0] PRDATA,
  output var  logic        PSEL,
  output var  logic        PENABLE,
  output var  logic        PWRITE,
  output var  logic [11:0] PADDR,
  output var  logic [31:0] PWDATA
);
  initial {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n = 0;
    @(posedge CLK);
    {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (!PREADY && ++n < 20);
    if (n == 20) begin
      testbench.n_mismatch++;
      testbench.results();
    end
    r = PRDATA;
    e = PSLVERR;
    {PSEL, PENABLE} <= 2'b00;
  endtask
endmodule
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench import oam_pkg::*; ;
  typedef struct packed {
    logic [7:0]  rv, av;
    logic [11:0] ins;
    logic [7:0]  ea, er;
    logic        ez;
  } oam_row_t;
  logic CLK = 0, SYS_RST = 1, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, ZERO, e;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, r;
  logic [7:0]  ACC;
  int n_mismatch = 0, cmp_count = 0;
  oam_row_t t[7] = '{
    '{8'h13, 8'h9A, 12'hD35, 8'hBF, 8'h13, 1'b0},
    '{8'h13, 8'h00, 12'hD00, 8'h00, 8'h13, 1'b1},
    '{8'h13, 8'h91, 12'h103, 8'h93, 8'h13, 1'b0},
    '{8'h13, 8'h91, 12'h123, 8'h91, 8'h93, 1'b0},
    '{8'h00, 8'h55, 12'h203, 8'h00, 8'h00, 1'b1},
    '{8'h00, 8'h55, 12'h223, 8'h55, 8'h00, 1'b1},
    '{8'h80, 8'h00, 12'h223, 8'h00, 8'h80, 1'b0}};
  always #5 CLK = ~CLK;
  oam_slice u_oam_slice(.CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PRDATA, .PREADY, .PSLVERR, .ACC, .ZERO);
  oam_fetch u_oam_fetch(.CLK, .PREADY, .PSLVERR, .PRDATA, .PSEL, .PENABLE,
    .PWRITE, .PADDR, .PWDATA);
  task automatic chk(input logic [31:0] s, x);
    cmp_count++;
    if (s !== x) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, s, x);
    end
  endtask
  task automatic results;
    if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge CLK);
    SYS_RST <= 1'b0;
    foreach (t[i]) begin
      u_oam_fetch.bus(1'b1, 12'h08C, 32'(t[i].rv), r, e);
      u_oam_fetch.bus(1'b1, 12'h004, 32'(t[i].av), r, e);
      u_oam_fetch.bus(1'b1, 12'h008, {31'h0000_0000, ~t[i].ez}, r, e);
      u_oam_fetch.bus(1'b1, 12'h000, 32'(t[i].ins), r, e);
      u_oam_fetch.bus(1'b0, 12'h004, 32'h0, r, e);
      chk(32'(ZERO), 32'(t[i].ez));
      chk(r, 32'(t[i].ea));
      chk(32'(ACC), 32'(t[i].ea));
      u_oam_fetch.bus(1'b0, 12'h08C, 32'h0, r, e);
      chk(r, 32'(t[i].er));
    end
    u_oam_fetch.bus(1'b1, 12'h0FC, 32'h7, r, e);
    u_oam_fetch.bus(1'b1, 12'h000, 32'h21F, r, e);
    u_oam_fetch.bus(1'b0, 12'h004, 32'h0, r, e);
    chk(r, 32'h7);
    u_oam_fetch.bus(1'b0, 12'h100, 32'h0, r, e);
    chk(32'(e), 32'h1);
    chk(r, 32'h0000_0000);
    u_oam_fetch.bus(1'b1, 12'h000, 32'h0000_0000, r, e);
    u_oam_fetch.bus(1'b0, 12'h008, 32'h0000_0000, r, e);
    chk(r, 32'h0000_0002);
    chk(32'(ACC), 32'h0000_0007);
    u_oam_fetch.bus(1'b1, 12'h008, 32'h0000_0003, r, e);
    u_oam_fetch.bus(1'b0, 12'h008, 32'h0000_0000, r, e);
    chk(r, 32'h0000_0001);
    u_oam_fetch.bus(1'b1, 12'h004, 32'h0000_00FF, r, e);
    SYS_RST <= 1'b1;
    repeat (2) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(posedge CLK);
    chk(32'({ACC, ZERO}), 32'h0000_0000);
    u_oam_fetch.bus(1'b0, 12'h0FC, 32'h0000_0000, r, e);
    chk(r, 32'h0000_0000);
    results();
  end
endmodule
`default_nettype wire
